// File: verilog/sps_map.svh
// Operation
// [R1] No pending status: NAK interrupt pipe requests
// [R2] Pending status: send two bytes, byte 0 first
// [R3] Byte 0: user bits high, GPIO levels low
// [R4] Byte 1: bus power, speed, ready, zeros
// [R5] Service request latches flag and status snapshot
// [R6] Test code selects mode, zero is normal
// [R7] Code 0010 after reset floats all outputs
// [R8] Code 0011: input XNOR chain onto bidis
// [R9] Code 0100: bidi XNOR chain onto outputs
// [R10] Media input polarity and enable configurable
// [R11] Media absent: drop pullup, halt ATA, low power
// [R12] Media back: pullup, ATA run, pins driven
// [R13] Grant low: float ATA pins, pause ATA
// [R14] Grant rising: reset drive, then resume
// [R15] Host avoids dropping grant mid transfer
// [R16] GPIO settings come from config bytes 0E, 0F
// [R17] Speed enable bit makes GPIO2 show speed
// [R18] Suspend indicator floats suspended, low active
// [R19] Chip reset held at least 1 ms
// [R20] ATA pullup follows bus activity, floats ungranted
// [R21] Drive ready filtered 25 ms, cleared at once
`ifndef SPS_MAP_SVH
`define SPS_MAP_SVH
`define SPS_CFG_READY     8'h05
`define SPS_CFG_MEDIA     8'h0B
`define SPS_CFG_GPIO_A    8'h0E
`define SPS_CFG_GPIO_B    8'h0F
`define SPS_STATUS        8'h10
`define SPS_READY_POL_BIT 0
`define SPS_MEDIA_EN_BIT  2
`define SPS_MEDIA_POL_BIT 4
`define SPS_SPEED_EN_BIT  4
`define SPS_GPIO2         2
`define SPS_RST_READY     8'h01
`define SPS_RST_MEDIA     8'h00
`define SPS_RST_GPIO_A    8'h00
`define SPS_RST_GPIO_B    8'h00
`define SPS_INT_B0        7:0
`define SPS_INT_B1        15:8
`define SPS_USER_BITS     7:3
`define SPS_GPIO_BITS     2:0
`define SPS_STRAP_WAIT    2'h3
`define SPS_READY_FILT_MS 25
`define SPS_CLK_KHZ       250000
`define SPS_CLK_MHZ       250
`define SPS_DRV_RST_NS    1000
`endif

// File: verilog/sps_pkg.sv
`default_nettype none
package sps_pkg;
	typedef enum logic [3:0] {
		SPS_NORMAL = 4'b0000,
		SPS_RSVD   = 4'b0001,
		SPS_LIMBO  = 4'b0010,
		SPS_XIN    = 4'b0011,
		SPS_XBIDI  = 4'b0100
	} spsMode_t;
	typedef enum logic [1:0] {
		SPS_IDLE  = 2'b00,
		SPS_BYTE0 = 2'b01,
		SPS_BYTE1 = 2'b10
	} spsTx_t;
	typedef struct packed {
		logic [4:0] zeros;
		logic       ready;
		logic       highSpeed;
		logic       busPowered;
		logic [4:0] userBits;
		logic [2:0] gpio;
	} spsIntWord_t;
	typedef struct packed {
		logic       driveResetN;
		logic       diowN;
		logic       diorN;
		logic       dmackN;
		logic [1:0] csN;
		logic [2:0] da;
	} spsAtaPins_t;
endpackage : sps_pkg
`default_nettype wire

// File: verilog/sps_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "sps_map.svh"
module sps_top #(
	parameter int unsigned READY_FILT_CYC =
		`SPS_READY_FILT_MS * `SPS_CLK_KHZ,
	parameter int unsigned DRV_RST_CYC =
		(`SPS_DRV_RST_NS * `SPS_CLK_MHZ + 999) / 1000
) (
	// Clock and reset
	input  wire logic           clk,
	input  wire logic           srst,
	// Register port
	input  wire logic [7:0]     regAddr,
	input  wire logic [7:0]     regWdata,
	input  wire logic           regWr,
	input  wire logic           regRd,
	output logic [7:0]          regRdata,
	// Interrupt pipe, USB engine side
	input  wire logic           intReq,
	input  wire logic           intAck,
	output logic                intNak,
	output logic                intValid,
	output logic                intLast,
	output logic [7:0]          intByte,
	// USB engine state
	input  wire logic           highSpeedFlag,
	input  wire logic           usbSuspended,
	// ATA engine side
	input  wire sps_pkg::spsAtaPins_t engPins,
	input  wire logic [15:0]    engDdOut,
	input  wire logic           engDdDrive,
	input  wire logic           engScl,
	input  wire logic           engHighPowerGrantN,
	output logic                ataRun,
	output logic                lowPowerReq,
	output logic                dPullupEn,
	// Board inputs
	input  wire logic           systemServiceRequest,
	input  wire logic           driveReadyInput,
	input  wire logic           busPoweredSelect,
	input  wire logic           mediaPresentInput,
	input  wire logic           ataBusGrant,
	input  wire logic           vbusPresentInput,
	input  wire logic           ejectRequestN,
	input  wire logic           ataIrqIn,
	input  wire logic           ioReadyIn,
	input  wire logic           dmaReqIn,
	input  wire logic           chipResetN,
	input  wire logic [3:0]     testSel,
	// Bidirectional pins
	input  wire logic [2:0]     gpioIn,
	output logic [2:0]          gpioOut,
	output logic [2:0]          gpioOeN,
	input  wire logic [15:0]    ddIn,
	output logic [15:0]         ddOut,
	output logic                ddOeN,
	input  wire logic           sdaIn,
	output logic                sdaOut,
	output logic                sdaOeN,
	// Output-only pins
	output var sps_pkg::spsAtaPins_t ataPinsOut,
	output logic                ataPinsOeN,
	output logic                ataPullupControl,
	output logic                ataPullupOeN,
	output logic                suspendIndicator,
	output logic                suspendOeN,
	output logic                sclOut,
	output logic                sclOeN,
	output logic                highPowerGrantN,
	output logic                highPowerGrantOeN
);
	import sps_pkg::*;

	localparam int RW = $clog2(READY_FILT_CYC + 1);
	localparam int DW = $clog2(DRV_RST_CYC + 1);
	localparam int SN = 35;

	function automatic logic xnorChain(input logic [19:0] v,
		input int n);
		logic r;
		r = v[0];
		for (int i = 1; i < n; i++) begin
			r = ~(r ^ v[i]);
		end
		return r;
	endfunction : xnorChain

	function automatic spsMode_t decodeMode(input logic [3:0] c);
		case (c)
			SPS_LIMBO: decodeMode = SPS_LIMBO;
			SPS_XIN:   decodeMode = SPS_XIN;
			SPS_XBIDI: decodeMode = SPS_XBIDI;
			// Reserved codes behave as normal operation
			default:   decodeMode = SPS_NORMAL;
		endcase
	endfunction : decodeMode

	// Pin synchronisers
	logic [SN-1:0] asyncIn, sync1_r, sync2_r;
	assign asyncIn = {systemServiceRequest, driveReadyInput,
		busPoweredSelect, mediaPresentInput, ataBusGrant,
		vbusPresentInput, ejectRequestN, ataIrqIn, ioReadyIn, dmaReqIn,
		chipResetN, testSel, gpioIn, ddIn, sdaIn};
	always_ff @(posedge clk) begin
		sync1_r <= asyncIn;
		sync2_r <= sync1_r;
	end
	logic sreqS, readyS, busPowS, mediaS, grantS, vbusS, ejectS;
	logic irqS, iordyS, dmarqS, chipRstS, sdaS;
	logic [3:0] testS;
	logic [2:0] gpioS;
	logic [15:0] ddS;
	assign {sreqS, readyS, busPowS, mediaS, grantS, vbusS, ejectS, irqS,
		iordyS, dmarqS, chipRstS, testS, gpioS, ddS, sdaS} = sync2_r;

	// Mode is sampled shortly after reset release, once sync settles
	logic [1:0] strapCnt_r;
	spsMode_t   mode_r;
	always_ff @(posedge clk) begin
		if (srst) begin
			strapCnt_r <= 2'h0;
			mode_r     <= SPS_NORMAL;
		end else if (strapCnt_r != `SPS_STRAP_WAIT) begin
			strapCnt_r <= strapCnt_r + 2'h1;
			mode_r     <= decodeMode(testS); // [R6] [R7]
		end
	end

	// Configuration registers
	logic [7:0] cfgReady_r, cfgMedia_r, cfgGpioA_r, cfgGpioB_r;
	always_ff @(posedge clk) begin
		if (srst) begin
			cfgReady_r <= `SPS_RST_READY;
			cfgMedia_r <= `SPS_RST_MEDIA;
			cfgGpioA_r <= `SPS_RST_GPIO_A;
			cfgGpioB_r <= `SPS_RST_GPIO_B;
		end else if (regWr) begin
			case (regAddr)
				`SPS_CFG_READY:  cfgReady_r <= regWdata;
				`SPS_CFG_MEDIA:  cfgMedia_r <= regWdata;
				`SPS_CFG_GPIO_A: cfgGpioA_r <= regWdata; // [R16]
				`SPS_CFG_GPIO_B: cfgGpioB_r <= regWdata; // [R16]
				default: ;
			endcase
		end
	end

	logic mediaOk, readyLvl, speedEn, pending_r, readyOk_r;
	// [R10]
	assign mediaOk = !cfgMedia_r[`SPS_MEDIA_EN_BIT] ||
		(mediaS == cfgMedia_r[`SPS_MEDIA_POL_BIT]);
	assign readyLvl = (readyS == cfgReady_r[`SPS_READY_POL_BIT]);
	assign speedEn  = cfgGpioB_r[`SPS_SPEED_EN_BIT];

	always_ff @(posedge clk) begin
		if (srst) begin
			regRdata <= 8'h00;
		end else if (regRd) begin
			case (regAddr)
				`SPS_CFG_READY:  regRdata <= cfgReady_r;
				`SPS_CFG_MEDIA:  regRdata <= cfgMedia_r;
				`SPS_CFG_GPIO_A: regRdata <= cfgGpioA_r;
				`SPS_CFG_GPIO_B: regRdata <= cfgGpioB_r;
				`SPS_STATUS: regRdata <= {3'h0, pending_r, readyOk_r,
					mediaOk, grantS, ataRun};
				default:         regRdata <= 8'h00;
			endcase
		end else begin
			regRdata <= 8'h00;
		end
	end

	// Drive ready filter; only the asserting edge is delayed
	logic [RW-1:0] readyCnt_r;
	always_ff @(posedge clk) begin
		if (srst || !readyLvl) begin
			readyCnt_r <= '0; // [R21]
			readyOk_r  <= 1'b0; // [R21]
		end else if (readyCnt_r == RW'(READY_FILT_CYC - 1)) begin
			readyOk_r <= 1'b1; // [R21]
		end else begin
			readyCnt_r <= readyCnt_r + RW'(1);
		end
	end

	// Drive reset pulse on grant or ready arrival
	logic grantD_r, readyOkD_r, drvRst, rstStart;
	logic [DW-1:0] rstCnt_r;
	assign rstStart = (grantS && !grantD_r) || (readyOk_r && !readyOkD_r);
	always_ff @(posedge clk) begin
		if (srst) begin
			grantD_r   <= 1'b0;
			readyOkD_r <= 1'b0;
			rstCnt_r   <= '0;
		end else begin
			grantD_r   <= grantS;
			readyOkD_r <= readyOk_r;
			if (rstStart)
				rstCnt_r <= DW'(DRV_RST_CYC); // [R14]
			else if (rstCnt_r != '0)
				rstCnt_r <= rstCnt_r - DW'(1);
		end
	end
	assign drvRst = (rstCnt_r != '0);

	// Engine control
	always_ff @(posedge clk) begin
		if (srst) begin
			ataRun      <= 1'b0;
			lowPowerReq <= 1'b0;
			dPullupEn   <= 1'b0;
		end else begin
			// [R11] [R12] [R13] [R14]
			// Held off in the edge cycle too, or the engine runs one
			// cycle before the drive reset begins
			ataRun      <= mediaOk && grantS && readyOk_r && !drvRst &&
				!rstStart; // [R14]
			lowPowerReq <= !mediaOk; // [R11]
			dPullupEn   <= mediaOk && vbusS; // [R11] [R12]
		end
	end

	// Service request snapshot
	logic sreqD_r, sreqRise, newSince_r, txDone_r;
	spsIntWord_t snap_r, curWord, txWord_r;
	spsTx_t txState_r;
	logic takeReq;
	assign sreqRise = sreqS && !sreqD_r;
	assign takeReq  = intReq && (txState_r == SPS_IDLE);
	always_comb begin
		curWord            = '0; // [R4]
		curWord.ready      = readyOk_r; // [R4]
		curWord.highSpeed  = highSpeedFlag; // [R4]
		curWord.busPowered = busPowS; // [R4]
		curWord.userBits   = cfgGpioA_r[`SPS_USER_BITS]; // [R3]
		curWord.gpio       = gpioS; // [R3]
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			sreqD_r    <= 1'b0;
			pending_r  <= 1'b0;
			snap_r     <= '0;
			newSince_r <= 1'b0;
		end else begin
			sreqD_r <= sreqS;
			// A fresh request beats a concurrent acknowledge
			if (sreqRise) begin
				pending_r  <= 1'b1; // [R5]
				snap_r     <= curWord; // [R5]
				newSince_r <= 1'b1;
			end else begin
				if (intAck && txDone_r && !newSince_r)
					pending_r <= 1'b0; // [R5]
				if (takeReq && pending_r)
					newSince_r <= 1'b0;
			end
		end
	end

	// Interrupt pipe answer
	always_ff @(posedge clk) begin
		if (srst) begin
			txState_r <= SPS_IDLE;
			txWord_r  <= '0;
			txDone_r  <= 1'b0;
			intNak    <= 1'b0;
			intValid  <= 1'b0;
			intLast   <= 1'b0;
			intByte   <= 8'h00;
		end else begin
			intNak <= 1'b0;
			if (intAck)
				txDone_r <= 1'b0;
			case (txState_r)
				SPS_IDLE: begin
					intValid <= 1'b0;
					intLast  <= 1'b0;
					if (intReq && pending_r) begin
						txState_r <= SPS_BYTE0; // [R2]
						txWord_r  <= snap_r;
						intValid  <= 1'b1;
						intByte   <= snap_r[`SPS_INT_B0]; // [R2]
						txDone_r  <= 1'b0;
					end else if (intReq) begin
						intNak <= 1'b1; // [R1]
					end
				end
				SPS_BYTE0: begin
					txState_r <= SPS_BYTE1;
					intLast   <= 1'b1;
					intByte   <= txWord_r[`SPS_INT_B1]; // [R2]
				end
				SPS_BYTE1: begin
					txState_r <= SPS_IDLE;
					intValid  <= 1'b0;
					intLast   <= 1'b0;
					txDone_r  <= 1'b1;
				end
				default: txState_r <= SPS_IDLE;
			endcase
		end
	end

	// Pin outputs; one register stage keeps the pads glitch free
	logic xIn, xBi;
	assign xIn = xnorChain({9'h000, vbusS, busPowS, readyS, irqS,
		iordyS, dmarqS, chipRstS, grantS, mediaS, sreqS, ejectS}, 11);
	assign xBi = xnorChain({gpioS[0], gpioS[1], gpioS[2], ddS, sdaS}, 20);
	logic [2:0] gpioOut_nxt, gpioOeN_nxt;
	logic [15:0] ddOut_nxt;
	logic ddOeN_nxt, sdaOut_nxt, sdaOeN_nxt, ataOeN_nxt, puOut_nxt;
	logic puOeN_nxt, susOeN_nxt, sclOut_nxt, sclOeN_nxt;
	logic hpgOut_nxt, hpgOeN_nxt;
	spsAtaPins_t ataOut_nxt;
	always_comb begin
		gpioOut_nxt = 3'h0;
		gpioOeN_nxt = 3'h7;
		ddOut_nxt   = 16'h0000;
		ddOeN_nxt   = 1'b1;
		sdaOut_nxt  = 1'b0;
		sdaOeN_nxt  = 1'b1;
		ataOut_nxt  = '0;
		ataOeN_nxt  = 1'b1;
		puOut_nxt   = 1'b0;
		puOeN_nxt   = 1'b1;
		susOeN_nxt  = 1'b1;
		sclOut_nxt  = 1'b0;
		sclOeN_nxt  = 1'b1;
		hpgOut_nxt  = 1'b0;
		hpgOeN_nxt  = 1'b1;
		case (mode_r)
			SPS_LIMBO: ; // [R7]
			SPS_XIN: begin
				gpioOut_nxt = {3{xIn}}; // [R8]
				gpioOeN_nxt = 3'h0;
				ddOut_nxt   = {16{xIn}}; // [R8]
				ddOeN_nxt   = 1'b0;
				sdaOut_nxt  = xIn;
				sdaOeN_nxt  = 1'b0;
			end
			SPS_XBIDI: begin
				ataOut_nxt = {$bits(spsAtaPins_t){xBi}}; // [R9]
				ataOeN_nxt = 1'b0;
				puOut_nxt  = xBi; // [R9]
				puOeN_nxt  = 1'b0;
				sclOut_nxt = xBi;
				sclOeN_nxt = 1'b0;
				hpgOut_nxt = xBi;
				hpgOeN_nxt = 1'b0;
				// Suspend pad is open drain, so it shows xBi by float
				susOeN_nxt = xBi;
			end
			default: begin
				gpioOut_nxt = cfgGpioA_r[`SPS_GPIO_BITS]; // [R16]
				gpioOeN_nxt = ~cfgGpioB_r[`SPS_GPIO_BITS]; // [R16]
				if (speedEn) begin
					gpioOut_nxt[`SPS_GPIO2] = !highSpeedFlag; // [R17]
					gpioOeN_nxt[`SPS_GPIO2] = 1'b0; // [R17]
				end
				sclOut_nxt = engScl;
				sclOeN_nxt = 1'b0;
				hpgOut_nxt = engHighPowerGrantN;
				hpgOeN_nxt = 1'b0;
				susOeN_nxt = usbSuspended; // [R18]
				if (grantS) begin
					// Halted engine drives every ATA line low
					ataOeN_nxt = 1'b0; // [R11] [R12]
					puOeN_nxt  = 1'b0; // [R20]
					puOut_nxt  = ataRun; // [R20]
					if (ataRun) begin
						ataOut_nxt = engPins;
						ddOut_nxt  = engDdOut;
						ddOeN_nxt  = !engDdDrive;
					end else begin
						ddOeN_nxt  = 1'b0; // [R11]
					end
				end
			end
		endcase
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			gpioOut           <= 3'h0;
			gpioOeN           <= 3'h7;
			ddOut             <= 16'h0000;
			ddOeN             <= 1'b1;
			sdaOut            <= 1'b0;
			sdaOeN            <= 1'b1;
			ataPinsOut        <= '0;
			ataPinsOeN        <= 1'b1;
			ataPullupControl  <= 1'b0;
			ataPullupOeN      <= 1'b1;
			suspendOeN        <= 1'b1;
			sclOut            <= 1'b0;
			sclOeN            <= 1'b1;
			highPowerGrantN   <= 1'b0;
			highPowerGrantOeN <= 1'b1;
		end else begin
			gpioOut           <= gpioOut_nxt;
			gpioOeN           <= gpioOeN_nxt;
			ddOut             <= ddOut_nxt;
			ddOeN             <= ddOeN_nxt;
			sdaOut            <= sdaOut_nxt;
			sdaOeN            <= sdaOeN_nxt;
			ataPinsOut        <= ataOut_nxt; // [R13]
			ataPinsOeN        <= ataOeN_nxt; // [R13]
			ataPullupControl  <= puOut_nxt;
			ataPullupOeN      <= puOeN_nxt; // [R20]
			suspendOeN        <= susOeN_nxt;
			sclOut            <= sclOut_nxt;
			sclOeN            <= sclOeN_nxt;
			highPowerGrantN   <= hpgOut_nxt;
			highPowerGrantOeN <= hpgOeN_nxt;
		end
	end
	assign suspendIndicator = 1'b0; // [R18]

	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	logic isNorm;
	assign isNorm = (mode_r == SPS_NORMAL);

	chk_nak_idle: assert property (takeReq && !pending_r |=> intNak) // [R1]
		else $error("request without pending status not NAKed");
	chk_word_order: assert property (takeReq && pending_r |=> // [R2]
		intValid && !intLast && intByte == $past(snap_r[`SPS_INT_B0])
		##1 intValid && intLast)
		else $error("status word bytes out of order");
	chk_byte1_top: assert property (intValid && intLast |-> // [R4]
		intByte[7:3] == 5'h00 && intByte[0] == txWord_r.busPowered)
		else $error("status byte 1 layout wrong");
	chk_pend_set: assert property (sreqRise |=> pending_r && // [R5] [R3]
		snap_r.gpio == $past(gpioS))
		else $error("service request not latched");
	chk_limbo_float: assert property (mode_r == SPS_LIMBO |=> // [R7]
		ataPinsOeN && ddOeN && gpioOeN == 3'h7 && sclOeN && sdaOeN)
		else $error("limbo mode output driven");
	chk_media_drop: assert property (!mediaOk |=> !dPullupEn && // [R11]
		lowPowerReq && !ataRun)
		else $error("media absent but bridge active");
	chk_grant_float: assert property (isNorm && !grantS |=> // [R13] [R20]
		ataPinsOeN && ataPullupOeN)
		else $error("ungranted ATA pins driven");
	chk_ready_filt: assert property ($rose(readyLvl) |-> // [R21]
		!readyOk_r [*8])
		else $error("drive ready accepted too early");
	chk_ready_drop: assert property (!readyLvl |=> !readyOk_r) // [R21]
		else $error("drive ready not cleared at once");
	chk_grant_reset: assert property (grantS && !grantD_r |=> // [R14]
		drvRst && !ataRun ##1 !ataRun)
		else $error("grant rise without drive reset");
	chk_speed_gpio: assert property (isNorm && speedEn |=> // [R17]
		gpioOut[`SPS_GPIO2] == !$past(highSpeedFlag) &&
		!gpioOeN[`SPS_GPIO2])
		else $error("GPIO2 not showing speed");
	chk_xnor_in: assert property (mode_r == SPS_XIN |=> // [R8]
		ddOut == {16{$past(xIn)}} && !ddOeN)
		else $error("input chain result missing");
	cov_word_sent: cover property (takeReq && pending_r ##2 intLast);
	cov_nak: cover property (takeReq && !pending_r);
	cov_grant_rise: cover property (grantS && !grantD_r);
	cov_ready_ok: cover property ($rose(readyOk_r));
endmodule : sps_top
`default_nettype wire

// File: bench/sps_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module sps_host_model (
	// Clock
	input  wire logic       clk,
	// Interrupt pipe
	output logic            intReq,
	output logic            intAck,
	input  wire logic       intNak,
	input  wire logic       intValid,
	input  wire logic       intLast,
	input  wire logic [7:0] intByte
);
	initial begin
		intReq = 1'b0;
		intAck = 1'b0;
	end
	// One IN token; ackDly < 0 leaves the word unacknowledged
	task automatic poll(input int ackDly, output logic nak,
		output logic [15:0] word);
		int n;
		nak = 1'bx;
		word = 16'hxxxx;
		@(posedge clk);
		intReq <= 1'b1;
		@(posedge clk);
		intReq <= 1'b0;
		n = 0;
		while (intNak !== 1'b1 && intValid !== 1'b1 && n < 4) begin
			@(posedge clk);
			n++;
		end
		if (intNak === 1'b1) begin
			nak = 1'b1;
		end else if (intValid === 1'b1) begin
			nak = 1'b0;
			word[7:0] = intByte;
			@(posedge clk);
			word[15:8] = (intLast === 1'b1) ? intByte : 8'hxx;
			// Ack only once the second byte has gone by
			if (ackDly >= 0) begin
				repeat (ackDly + 1) @(posedge clk);
				intAck <= 1'b1;
				@(posedge clk);
				intAck <= 1'b0;
			end
		end
	endtask : poll
endmodule : sps_host_model
`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
	import sps_pkg::*;
	localparam int LIMIT = 20000;
	typedef struct {
		logic [2:0]  gpio;
		logic [4:0]  user;
		logic        bp;
		logic        hs;
		logic [15:0] word;
	} spsRow_t;
	logic clk, srst, regWr, regRd, intReq, intAck, intNak, intValid, intLast;
	logic [7:0] regAddr, regWdata, regRdata, intByte, d;
	logic highSpeedFlag, usbSuspended, engDdDrive, engScl, engHighPowerGrantN;
	logic ataRun, lowPowerReq, dPullupEn, systemServiceRequest, driveReadyInput;
	logic busPoweredSelect, mediaPresentInput, ataBusGrant, vbusPresentInput;
	logic ejectRequestN, ataIrqIn, ioReadyIn, dmaReqIn, chipResetN, r;
	logic sdaIn, sdaOut, sdaOeN, ddOeN, ataPinsOeN, ataPullupControl;
	logic ataPullupOeN, suspendIndicator, suspendOeN, sclOut, sclOeN;
	logic highPowerGrantN, highPowerGrantOeN;
	logic [3:0] testSel;
	logic [2:0] gpioIn, gpioOut, gpioOeN;
	logic [15:0] ddIn, ddOut, engDdOut;
	spsAtaPins_t engPins, ataPinsOut;
	int fails = 0;
	int nCompared = 0;
	int cycles = 0;
	int lowCnt = 0;
	spsRow_t rows[4] = '{
		'{3'h0, 5'h00, 1'b0, 1'b0, 16'h0400},
		'{3'h7, 5'h1F, 1'b1, 1'b1, 16'h07FF},
		'{3'h5, 5'h0A, 1'b1, 1'b0, 16'h0555},
		'{3'h2, 5'h15, 1'b0, 1'b1, 16'h06AA}};
	logic [7:0] ra[5] = '{8'h05, 8'h0B, 8'h0E, 8'h0F, 8'h20};
	logic [7:0] rv[5] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [3:0] rsv[3] = '{4'h1, 4'h5, 4'hF};

	sps_top #(.READY_FILT_CYC(20), .DRV_RST_CYC(4)) u_sps_top (
		.clk, .srst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
		.intReq, .intAck, .intNak, .intValid, .intLast, .intByte,
		.highSpeedFlag, .usbSuspended, .engPins, .engDdOut, .engDdDrive,
		.engScl, .engHighPowerGrantN, .ataRun, .lowPowerReq, .dPullupEn,
		.systemServiceRequest, .driveReadyInput, .busPoweredSelect,
		.mediaPresentInput, .ataBusGrant, .vbusPresentInput, .ejectRequestN,
		.ataIrqIn, .ioReadyIn, .dmaReqIn, .chipResetN, .testSel, .gpioIn,
		.gpioOut, .gpioOeN, .ddIn, .ddOut, .ddOeN, .sdaIn, .sdaOut, .sdaOeN,
		.ataPinsOut, .ataPinsOeN, .ataPullupControl, .ataPullupOeN,
		.suspendIndicator, .suspendOeN, .sclOut, .sclOeN, .highPowerGrantN,
		.highPowerGrantOeN);
	sps_host_model u_sps_host_model (.clk, .intReq, .intAck, .intNak,
		.intValid, .intLast, .intByte);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			fails++;
			finish_test();
		end
	end

	task automatic finish_test();
		if (fails == 0 && nCompared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : finish_test
	task automatic chk_v(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		nCompared++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_v
	task automatic chk_b(input string nm, input logic e, input logic g);
		nCompared++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s expected %b seen %b", nm, e, g);
		end
	endtask : chk_b
	task automatic chk_int(input string nm, input int ackDly,
		input logic eNak, input logic [15:0] eWord);
		logic nak;
		logic [15:0] w;
		u_sps_host_model.poll(ackDly, nak, w);
		nCompared++;
		if (nak !== eNak || (eNak == 1'b0 && w !== eWord)) begin
			fails++;
			$display("[ERR] %s expected %b %h seen %b %h", nm, eNak, eWord,
				nak, w);
		end
	endtask : chk_int
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask : wt
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		regWr <= 1'b1;
		regAddr <= a;
		regWdata <= v;
		@(posedge clk);
		regWr <= 1'b0;
	endtask : reg_wr
	task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		regRd <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 1'b0;
		@(posedge clk);
		v = regRdata;
	endtask : reg_rd
	task automatic rst(input logic [3:0] mode);
		@(posedge clk);
		srst <= 1'b1;
		testSel <= mode;
		// Far shorter than the board reset, enough for the sync logic
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		wt(10);
	endtask : rst
	task automatic svc();
		systemServiceRequest <= 1'b1;
		wt(4);
		systemServiceRequest <= 1'b0;
		wt(6);
	endtask : svc

	initial begin
		srst = 1'b1;
		testSel = 4'h0;
		{regWr, regRd, highSpeedFlag, usbSuspended, systemServiceRequest} = '0;
		{busPoweredSelect, ataIrqIn, ioReadyIn, dmaReqIn, sdaIn} = '0;
		{engDdDrive, engScl} = '0;
		{driveReadyInput, mediaPresentInput, ataBusGrant} = '1;
		{vbusPresentInput, ejectRequestN, chipResetN, engHighPowerGrantN} = '1;
		regAddr = 8'h00;
		regWdata = 8'h00;
		gpioIn = 3'h0;
		ddIn = 16'h0000;
		engDdOut = 16'h0000;
		engPins = '1;
		rst(4'h0);
		reg_wr(8'h20, 8'hFF);
		foreach (ra[i]) begin
			reg_rd(ra[i], d);
			chk_v("reg", {8'h00, rv[i]}, {8'h00, d});
		end
		chk_int("idle_nak", 0, 1'b1, 16'h0000);
		foreach (rows[i]) begin
			gpioIn <= rows[i].gpio;
			busPoweredSelect <= rows[i].bp;
			highSpeedFlag <= rows[i].hs;
			reg_wr(8'h0E, {rows[i].user, 3'h0});
			wt(6);
			svc();
			chk_int("word", 0, 1'b0, rows[i].word);
			chk_int("cleared", 0, 1'b1, 16'h0000);
		end
		gpioIn <= 3'h3;
		wt(6);
		svc();
		// Snapshot must hold the levels seen at the request
		gpioIn <= 3'h4;
		wt(6);
		chk_int("noack", -1, 1'b0, 16'h06AB);
		chk_int("slowack", 3, 1'b0, 16'h06AB);
		chk_int("acked", 0, 1'b1, 16'h0000);
		driveReadyInput <= 1'b0;
		wt(8);
		chk_b("rdy_off", 1'b0, ataRun);
		driveReadyInput <= 1'b1;
		wt(15);
		chk_b("rdy_filt", 1'b0, ataRun);
		wt(30);
		chk_b("rdy_run", 1'b1, ataRun);
		chk_b("pu_on", 1'b1, ataPullupControl);
		reg_rd(8'h10, d);
		chk_v("status", 16'h000F, {8'h00, d});
		ataBusGrant <= 1'b0;
		wt(8);
		chk_b("g_float", 1'b1, ataPinsOeN);
		chk_b("g_pufl", 1'b1, ataPullupOeN);
		chk_b("g_pause", 1'b0, ataRun);
		chk_b("g_usb", 1'b1, dPullupEn);
		ataBusGrant <= 1'b1;
		// A bare grant return drives the lines low for at least four cycles of drive reset
		lowCnt = 0;
		repeat (14) begin
			@(posedge clk);
			if (ataPinsOeN === 1'b0 && ataPinsOut.driveResetN === 1'b0) begin
				lowCnt++;
			end
		end
		chk_b("g_drvrst", 1'b1, lowCnt >= 4);
		wt(8);
		chk_b("g_run", 1'b1, ataRun);
		chk_v("g_pins", 16'h01FF, {7'h00, ataPinsOut});
		reg_wr(8'h0B, 8'h14);
		mediaPresentInput <= 1'b0;
		wt(8);
		chk_b("m_pu", 1'b0, dPullupEn);
		chk_b("m_lp", 1'b1, lowPowerReq);
		chk_b("m_halt", 1'b0, ataRun);
		chk_v("m_low", 16'h0000, {7'h00, ataPinsOut});
		chk_b("m_drv", 1'b0, ataPinsOeN);
		mediaPresentInput <= 1'b1;
		wt(40);
		chk_b("m_back", 1'b1, dPullupEn);
		chk_b("m_run", 1'b1, ataRun);
		reg_wr(8'h0B, 8'h04);
		wt(8);
		chk_b("m_pol", 1'b1, lowPowerReq);
		reg_wr(8'h0B, 8'h00);
		wt(8);
		chk_b("m_dis", 1'b0, lowPowerReq);
		reg_wr(8'h0E, 8'h05);
		reg_wr(8'h0F, 8'h13);
		reg_rd(8'h0F, d);
		chk_v("rd_0f", 16'h0013, {8'h00, d});
		for (int h = 0; h < 2; h++) begin
			highSpeedFlag <= 1'(h);
			wt(6);
			chk_v("gpio", 16'h0001, {12'h000, gpioOeN[1:0], gpioOut[1:0]});
			chk_b("gpio2", (h == 0), gpioOut[2]);
		end
		for (int s = 1; s >= 0; s--) begin
			usbSuspended <= 1'(s);
			wt(6);
			chk_b("susp_oe", 1'(s), suspendOeN);
			chk_b("susp_lvl", 1'b0, suspendIndicator);
		end
		foreach (rsv[i]) begin
			rst(rsv[i]);
			chk_b("rsv", 1'b0, ataPinsOeN);
		end
		rst(4'h2);
		chk_v("limbo", 16'h03FF, {6'h00, gpioOeN, ddOeN, sdaOeN, ataPinsOeN,
			ataPullupOeN, suspendOeN, sclOeN, highPowerGrantOeN});
		rst(4'h3);
		for (int k = 0; k < 2; k++) begin
			ejectRequestN <= 1'(k);
			wt(6);
			r = ^{vbusPresentInput, busPoweredSelect, driveReadyInput, ataIrqIn,
				ioReadyIn, dmaReqIn, chipResetN, ataBusGrant, mediaPresentInput,
				systemServiceRequest, ejectRequestN};
			chk_v("xin_dd", {16{r}}, ddOut);
			chk_v("xin_gp", {12'h000, {4{r}}}, {12'h000, sdaOut, gpioOut});
			chk_b("xin_oe", 1'b0, ddOeN);
		end
		rst(4'h4);
		ddIn <= 16'hA5C3;
		gpioIn <= 3'h5;
		for (int k = 0; k < 2; k++) begin
			sdaIn <= 1'(k);
			wt(6);
			r = ~^{gpioIn, ddIn, sdaIn};
			chk_b("xb_pu", r, ataPullupControl);
			chk_b("xb_scl", r, sclOut);
			chk_b("xb_susp", r, suspendOeN);
			chk_b("xb_hpg", r, highPowerGrantN);
			chk_v("xb_ata", {7'h00, {9{r}}}, {7'h00, ataPinsOut});
		end
		finish_test();
	end
endmodule : tb
`default_nettype wire
